// File: hdl/tdq_burst_buf.sv
`timescale 1ns/10ps
module tdq_burst_buf
  import tdq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic push,
  input wire logic [31:0] pushData,
  input wire logic pop,
  output logic [31:0] head,
  output logic [3:0] count,
  output logic full
);
  import tdq_pkg::*;

  logic [31:0] mem [BUF_DEPTH];
  logic [2:0] wrIdx;
  logic [2:0] rdIdx;

  // Storage for up to eight one-dword entries
  always_ff @(posedge ref_clk) begin
    if (push && !full) begin
      mem[wrIdx] <= pushData;
    end
  end

  // Indices and fill level; push and pop may share a cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrIdx <= 3'h0;
      rdIdx <= 3'h0;
      count <= 4'h0;
    end else begin
      if (push && !full) begin
        wrIdx <= wrIdx + 3'h1;
      end
      if (pop && count != 4'h0) begin
        rdIdx <= rdIdx + 3'h1;
      end
      count <= count + 4'((push && !full) ? 1 : 0) - 4'((pop && count != 4'h0) ? 1 : 0);
    end
  end

  assign head = mem[rdIdx];
  assign full = (count == 4'(BUF_DEPTH));

  property p_count_bound;
    @(posedge ref_clk) disable iff (!rstn) count <= 4'(BUF_DEPTH);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("buffer overfilled");
endmodule

// File: hdl/tdq_flush_timer.sv
`timescale 1ns/10ps
module tdq_flush_timer
  import tdq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic reload,
  input wire logic [15:0] reloadValue,
  output logic expired
);
  import tdq_pkg::*;

  logic [7:0] divCnt;
  logic tick;
  logic [16:0] remain;

  // Clock divided by 256 as a one-cycle enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end
  assign tick = (divCnt == 8'(TIMER_DIV_CYCLES - 1));

  // Count down in ticks; reloaded on each queue write or while burst mode is off
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      remain <= 17'h00000;
    end else if (!enable || reload) begin
      remain <= tdq_reload(reloadValue);
    end else if (tick && remain != 17'h00000) begin
      remain <= remain - 17'h00001;
    end
  end

  // Ignored entirely when burst mode is off
  assign expired = enable && (remain == 17'h00000);

  property p_reload;
    @(posedge ref_clk) disable iff (!rstn)
      (enable && reload) |=> (remain == tdq_reload($past(reloadValue)));
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");

  property p_tick_gap;
    @(posedge ref_clk) disable iff (!rstn) tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("timer ticks too often");
endmodule

// File: hdl/tdq_writer.sv
`timescale 1ns/10ps
// How it works
// - Full when read pointer one ahead
// - Entry address is base plus four times write pointer
// - Advance pointer; past end offset wraps zero
// - End offset counts dwords from base
// - No writes until master enable set
// - Write status after 1 to 128 writes
// - No room: error, no write, no advance
// - Enabled status flags raise interrupt request
// - Burst buffer holds eight entries
// - Burst mode waits for six entries
// - Burst only as many as fit
// - Buffer with no queue room sets write error
// - Burst off: one entry per write
// - Flush bit drains buffer; software clears it
// - 16-bit timer ticks every 256 clocks
// - Timer used only in burst mode
// - Every queue write reloads the timer
// - 0001h reloads 1, FFFFh reloads 65536
// - Equal pointers mean empty queue
// - Device owns write, host read pointer
// - Entry: descriptor, channel, status fields
module tdq_writer
  import tdq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [11:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic txDmaMasterEnable,
  input wire logic queueWriteIntEnable,
  input wire logic queueWriteErrorIntEnable,
  input wire logic entryValid,
  output logic entryReady,
  input wire logic [15:0] entryDescPtr,
  input wire logic [7:0] entryChannel,
  input wire logic [2:0] entryStatus,
  output logic memReq,
  output logic [31:0] memAddr,
  output logic [31:0] memData,
  output logic memLast,
  input wire logic memAck,
  output logic queueWriteStatus,
  output logic queueWriteErrorStatus,
  output logic statusIrq
);
  import tdq_pkg::*;

  logic [15:0] baseLow;
  logic [15:0] baseHigh;
  logic [15:0] endOffset;
  logic [15:0] readPtr;
  logic [15:0] writePtr;
  logic [15:0] timerCount;
  logic [15:0] ctrl;
  tdq_state_t state;
  tdq_state_t next_state;
  logic [3:0] beatsLeft;
  logic [7:0] thrCount;
  logic [31:0] entryWord;
  logic [31:0] bufHead;
  logic [3:0] bufCount;
  logic bufFull;
  logic bufPop;
  logic timerExpired;
  logic burstEnable;
  logic flushBit;
  logic [16:0] freeSlots;
  logic [3:0] fitBeats;
  logic startDrain;
  logic dropEntry;
  logic writeDone;
  logic queueFull;
  logic queueEmpty;
  logic [8:0] thrLimit;

  // ==========================================================
  // Register file
  assign burstEnable = ctrl[BURST_EN_BIT];
  assign flushBit = ctrl[FLUSH_BIT];

  // Host writes; the write pointer is only for initialisation
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      baseLow <= REG_RESET;
      baseHigh <= REG_RESET;
      endOffset <= REG_RESET;
      readPtr <= REG_RESET;
      timerCount <= TIMER_RESET;
      ctrl <= REG_RESET;
    end else if (regWrEn) begin
      case (regAddr)
        BASE_LOW_OFS: baseLow <= regWrData;
        BASE_HIGH_OFS: baseHigh <= regWrData;
        END_OFS: endOffset <= regWrData;
        READ_PTR_OFS: readPtr <= regWrData;
        FLUSH_TIMER_OFS: timerCount <= regWrData;
        CTRL_OFS: ctrl <= regWrData & CTRL_MASK;
        default: ;
      endcase
    end
  end

  // Device advance wins over a host write in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      writePtr <= REG_RESET;
    end else if (writeDone) begin
      writePtr <= tdq_next_ptr(writePtr, endOffset);
    end else if (regWrEn && regAddr == WRITE_PTR_OFS) begin
      writePtr <= regWrData;
    end
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= REG_RESET;
    end else if (regRdEn) begin
      case (regAddr)
        BASE_LOW_OFS: regRdData <= baseLow;
        BASE_HIGH_OFS: regRdData <= baseHigh;
        END_OFS: regRdData <= endOffset;
        READ_PTR_OFS: regRdData <= readPtr;
        WRITE_PTR_OFS: regRdData <= writePtr;
        FLUSH_TIMER_OFS: regRdData <= timerCount;
        CTRL_OFS: regRdData <= ctrl;
        default: regRdData <= REG_RESET;
      endcase
    end
  end

  // ==========================================================
  // Queue space
  assign freeSlots = tdq_free(writePtr, readPtr, endOffset);
  assign queueFull = (tdq_next_ptr(writePtr, endOffset) == readPtr);
  assign queueEmpty = (writePtr == readPtr);
  // Beats limited by what the queue can take without overflowing
  assign fitBeats = (freeSlots < {13'h0000, bufCount}) ? freeSlots[3:0] : bufCount;

  // ==========================================================
  // Entry intake and buffer
  always_comb begin
    entryWord = 32'h00000000;
    entryWord[DESC_LSB +: 16] = entryDescPtr;
    entryWord[CHAN_LSB +: 8] = entryChannel;
    entryWord[STAT_LSB +: 3] = entryStatus;
  end

  // Back-pressure when the buffer is full
  assign entryReady = !bufFull;
  assign writeDone = (state == S_WAIT) && memAck;
  assign bufPop = writeDone || dropEntry;

  tdq_burst_buf i_tdq_burst_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .push(entryValid),
    .pushData(entryWord),
    .pop(bufPop),
    .head(bufHead),
    .count(bufCount),
    .full(bufFull)
  );

  tdq_flush_timer i_tdq_flush_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(burstEnable),
    .reload(writeDone),
    .reloadValue(timerCount),
    .expired(timerExpired)
  );

  // ==========================================================
  // Write sequencer
  // Single mode drains each entry; burst waits for watermark,
  // flush or timer expiry
  assign startDrain = (state == S_IDLE) && txDmaMasterEnable && (bufCount != 4'h0) &&
    (!burstEnable || bufCount >= WATERMARK || flushBit || timerExpired);
  // A blocked entry is lost rather than stalling the transmit path
  assign dropEntry = startDrain && (freeSlots == 17'h00000);

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (startDrain && !dropEntry) next_state = S_ISSUE;
      S_ISSUE: next_state = S_WAIT;
      S_WAIT: if (memAck) next_state = (beatsLeft == 4'h1) ? S_IDLE : S_ISSUE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Beats left in the current burst
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      beatsLeft <= 4'h0;
    end else if (startDrain && !dropEntry) begin
      beatsLeft <= burstEnable ? fitBeats : 4'h1;
    end else if (writeDone) begin
      beatsLeft <= beatsLeft - 4'h1;
    end
  end

  // Memory write beat, held until acknowledged
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      memReq <= 1'b0;
      memAddr <= 32'h00000000;
      memData <= 32'h00000000;
      memLast <= 1'b0;
    end else if (state == S_ISSUE) begin
      memReq <= 1'b1;
      memAddr <= {baseHigh, baseLow} + {14'h0000, writePtr, 2'b00};
      memData <= bufHead;
      memLast <= (beatsLeft == 4'h1);
    end else if (writeDone) begin
      memReq <= 1'b0;
      memLast <= 1'b0;
    end
  end

  // ==========================================================
  // Status
  assign thrLimit = 9'h001 << ctrl[THR_LSB +: 3];

  // Write status after the programmed number of writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      thrCount <= 8'h00;
      queueWriteStatus <= 1'b0;
    end else if (writeDone && ({1'b0, thrCount} + 9'h001 >= thrLimit)) begin
      thrCount <= 8'h00;
      queueWriteStatus <= 1'b1;
    end else begin
      thrCount <= thrCount + 8'(writeDone ? 1 : 0);
      queueWriteStatus <= 1'b0;
    end
  end

  // Error pulse and interrupt request one cycle after the event
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      queueWriteErrorStatus <= 1'b0;
    end else begin
      queueWriteErrorStatus <= dropEntry;
    end
  end

  assign statusIrq = (queueWriteStatus && queueWriteIntEnable) ||
    (queueWriteErrorStatus && queueWriteErrorIntEnable);

  // ==========================================================
  // Checks
  property p_addr;
    @(posedge ref_clk) disable iff (!rstn)
      memReq |-> memAddr == {baseHigh, baseLow} + {14'h0000, writePtr, 2'b00};
  endproperty
  a_addr: assert property (p_addr) else $error("entry address wrong");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rstn)
      (writeDone && writePtr == endOffset) |=> writePtr == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  property p_advance;
    @(posedge ref_clk) disable iff (!rstn)
      (writeDone && writePtr < endOffset) |=> writePtr == $past(writePtr) + 16'h0001;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance");

  property p_enable;
    @(posedge ref_clk) disable iff (!rstn) $rose(memReq) |-> $past(txDmaMasterEnable, 2);
  endproperty
  a_enable: assert property (p_enable) else $error("write while disabled");

  property p_not_full;
    @(posedge ref_clk) disable iff (!rstn) (state == S_ISSUE) |-> !queueFull;
  endproperty
  a_not_full: assert property (p_not_full) else $error("write into full queue");

  property p_error;
    @(posedge ref_clk) disable iff (!rstn)
      dropEntry |=> queueWriteErrorStatus && writePtr == $past(writePtr) && !memReq;
  endproperty
  a_error: assert property (p_error) else $error("overflow not handled");

  property p_single;
    @(posedge ref_clk) disable iff (!rstn) (writeDone && !burstEnable) |-> memLast;
  endproperty
  a_single: assert property (p_single) else $error("multi-beat write in single mode");

  property p_watermark;
    @(posedge ref_clk) disable iff (!rstn)
      (state == S_IDLE && burstEnable && !flushBit && !timerExpired && bufCount < WATERMARK)
        |=> state == S_IDLE;
  endproperty
  a_watermark: assert property (p_watermark) else $error("burst below watermark");

  property p_irq;
    @(posedge ref_clk) disable iff (!rstn)
      (dropEntry && queueWriteErrorIntEnable) |=> statusIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("error interrupt missing");
endmodule

// File: pkg/tdq_pkg.sv
package tdq_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] BASE_LOW_OFS = 12'h830;
  localparam logic [11:0] BASE_HIGH_OFS = 12'h834;
  localparam logic [11:0] END_OFS = 12'h838;
  localparam logic [11:0] READ_PTR_OFS = 12'h83c;
  localparam logic [11:0] WRITE_PTR_OFS = 12'h840;
  localparam logic [11:0] FLUSH_TIMER_OFS = 12'h844;
  localparam logic [11:0] CTRL_OFS = 12'h880;
  // ==========================================================
  // Control field positions and reset values
  localparam int BURST_EN_BIT = 2;
  localparam int FLUSH_BIT = 3;
  localparam int THR_LSB = 8;
  localparam logic [15:0] CTRL_MASK = 16'h070f;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  // ==========================================================
  // Completion entry layout
  localparam int DESC_LSB = 0;
  localparam int CHAN_LSB = 16;
  localparam int STAT_LSB = 26;
  // ==========================================================
  // Buffer and timing
  localparam int BUF_DEPTH = 8;
  localparam logic [3:0] WATERMARK = 4'h6;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMER_DIV_CYCLES = 256;
  localparam logic [16:0] TIMER_MAX_RELOAD = 17'h10000;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} tdq_state_t;

  // Pointer after one entry, wrapping past the end offset
  function automatic logic [15:0] tdq_next_ptr(input logic [15:0] ptr,
                                               input logic [15:0] endOfs);
    logic [16:0] inc;
    inc = {1'b0, ptr} + 17'h00001;
    tdq_next_ptr = (inc > {1'b0, endOfs}) ? 16'h0000 : inc[15:0];
  endfunction

  // Free slots; one slot always kept empty so full differs from empty
  function automatic logic [16:0] tdq_free(input logic [15:0] wp,
                                           input logic [15:0] rp,
                                           input logic [15:0] endOfs);
    logic [16:0] size;
    logic [16:0] used;
    size = {1'b0, endOfs} + 17'h00001;
    used = (wp >= rp) ? {1'b0, wp} - {1'b0, rp} : size - {1'b0, rp} + {1'b0, wp};
    tdq_free = size - used - 17'h00001;
  endfunction

  // Programmed count to ticks: all ones means the full 2^16
  function automatic logic [16:0] tdq_reload(input logic [15:0] val);
    tdq_reload = (val == 16'hffff) ? TIMER_MAX_RELOAD : {1'b0, val};
  endfunction
endpackage

// File: testbench/tdq_host_mem.sv
`timescale 1ns/10ps
// ==========================================================
// Host memory behind the bus: accepts completion dwords
module tdq_host_mem (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic memReq,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memData,
  input wire logic memLast,
  input wire logic [3:0] ackDelay,
  output logic memAck
);
  logic [31:0] mem [0:255];
  logic [3:0] waitCnt;

  // Ack after ackDelay idle cycles; ack never held past one beat
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
    end else if (memReq && !memAck && waitCnt >= ackDelay) begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
    end else begin
      memAck <= 1'b0;
      waitCnt <= (memReq && !memAck) ? waitCnt + 4'h1 : 4'h0;
    end
  end

  // Store only; pointers are never touched from this side
  always_ff @(posedge ref_clk) begin
    if (memReq && memAck) begin
      mem[memAddr[9:2]] <= memData;
    end
  end
endmodule

// File: testbench/tx_done_queue_writer_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) check_eq(32'((g)), 32'((e)))
module tx_done_queue_writer_bench;
  import tdq_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] entryDescPtr = 16'h0000;
  logic [7:0] entryChannel = 8'h00;
  logic [2:0] entryStatus = 3'h0;
  logic txDmaMasterEnable = 1'b0;
  logic queueWriteIntEnable = 1'b0;
  logic queueWriteErrorIntEnable = 1'b0;
  logic entryValid = 1'b0;
  logic [3:0] ackDelay = 4'h0;
  logic [15:0] regRdData;
  logic entryReady, memReq, memLast, memAck, queueWriteStatus, queueWriteErrorStatus, statusIrq;
  logic [31:0] memAddr, memData, base;
  logic [15:0] wp, endOfs, rd;
  logic [31:0] beatAddr[$], beatData[$], expQ[$];
  logic beatLast[$];
  int fails = 0, cmp_count = 0, cyc = 0, wrPulses = 0, errPulses = 0;
  int irqCnt = 0, irqExp = 0, lastAck = 0, n0, t0;
  localparam logic [11:0] REG_OFS [7] = '{BASE_LOW_OFS, BASE_HIGH_OFS, END_OFS, READ_PTR_OFS,
    WRITE_PTR_OFS, FLUSH_TIMER_OFS, CTRL_OFS};

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  tdq_writer i_tdq_writer (.ref_clk(ref_clk), .rstn(rstn), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .txDmaMasterEnable(txDmaMasterEnable), .queueWriteIntEnable(queueWriteIntEnable),
    .queueWriteErrorIntEnable(queueWriteErrorIntEnable), .entryValid(entryValid),
    .entryReady(entryReady), .entryDescPtr(entryDescPtr), .entryChannel(entryChannel),
    .entryStatus(entryStatus), .memReq(memReq), .memAddr(memAddr), .memData(memData),
    .memLast(memLast), .memAck(memAck), .queueWriteStatus(queueWriteStatus),
    .queueWriteErrorStatus(queueWriteErrorStatus), .statusIrq(statusIrq));

  tdq_host_mem i_tdq_host_mem (.ref_clk(ref_clk), .rstn(rstn), .memReq(memReq),
    .memAddr(memAddr), .memData(memData), .memLast(memLast), .ackDelay(ackDelay),
    .memAck(memAck));

  // ==========================================================
  // Monitor: beats, pulses, interrupts and the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (memReq === 1'b1 && memAck === 1'b1) begin
      beatAddr.push_back(memAddr);
      beatData.push_back(memData);
      beatLast.push_back(memLast);
      lastAck = cyc;
    end
    if (queueWriteStatus === 1'b1) wrPulses++;
    if (queueWriteErrorStatus === 1'b1) errPulses++;
    if (statusIrq === 1'b1) irqCnt++;
    if ((queueWriteStatus === 1'b1 && queueWriteIntEnable === 1'b1) ||
        (queueWriteErrorStatus === 1'b1 && queueWriteErrorIntEnable === 1'b1)) irqExp++;
    if (cyc > 30000) begin
      fails++;
      give_verdict();
    end
  end

  // ==========================================================
  // Expectations and bus tasks
  function automatic logic [15:0] exp_next(input logic [15:0] p, input logic [15:0] e);
    exp_next = ({1'b0, p} + 17'h00001 > {1'b0, e}) ? 16'h0000 : p + 16'h0001;
  endfunction

  task automatic check_eq(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict();
    $display("counts: %0d comparisons, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  // Random entry, held until the buffer takes it
  task automatic push_entry();
    int i;
    logic [15:0] d;
    logic [7:0] c;
    logic [2:0] s;
    d = 16'($urandom);
    c = 8'($urandom);
    s = 3'($urandom);
    @(posedge ref_clk);
    entryValid <= 1'b1;
    entryDescPtr <= d;
    entryChannel <= c;
    entryStatus <= s;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (entryReady !== 1'b1 && i < 100);
    @(posedge ref_clk);
    entryValid <= 1'b0;
    expQ.push_back({3'b000, s, 2'b00, c, d});
  endtask

  // Bits 24 and 25 of an entry carry no meaning, so they are masked
  task automatic expect_beats(input int n, input bit burst);
    int i;
    i = 0;
    while (beatAddr.size() < n && i < 3000) begin
      @(posedge ref_clk);
      i++;
    end
    // Two more edges so the monitor has counted the last beat's status pulse
    repeat (2) @(posedge ref_clk);
    `CHK(beatAddr.size(), n);
    for (i = 0; i < n && beatAddr.size() > 0; i++) begin
      `CHK(beatAddr.pop_front(), base + {wp, 2'b00});
      `CHK(beatData.pop_front() & 32'h1cffffff, expQ.pop_front());
      `CHK(beatLast.pop_front(), !burst || i == n - 1);
      wp = exp_next(wp, endOfs);
    end
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    void'($urandom(32'hf9dd));
    for (int a = 0; a < 7; a++) begin
      reg_rd(REG_OFS[a], rd);
      `CHK(rd, REG_RESET);
    end
    reg_rd(12'h850, rd);
    `CHK(rd, 16'h0000);
    reg_wr(CTRL_OFS, 16'hffff);
    reg_rd(CTRL_OFS, rd);
    `CHK(rd, CTRL_MASK);
    reg_wr(CTRL_OFS, 16'h0000);
    base = {16'($urandom), 16'($urandom) & 16'hfffc};
    reg_wr(BASE_LOW_OFS, base[15:0]);
    reg_wr(BASE_HIGH_OFS, base[31:16]);
    endOfs = 16'h0003;
    reg_wr(END_OFS, endOfs);
    wp = 16'h0000;
    queueWriteErrorIntEnable <= 1'b1;
    $display("test registers done");
    push_entry();
    repeat (30) @(posedge ref_clk);
    `CHK(beatAddr.size(), 0);
    txDmaMasterEnable <= 1'b1;
    expect_beats(1, 1'b0);
    push_entry();
    push_entry();
    expect_beats(2, 1'b0);
    push_entry();
    repeat (30) @(posedge ref_clk);
    `CHK(beatAddr.size(), 0);
    `CHK(errPulses, 1);
    void'(expQ.pop_front());
    reg_rd(WRITE_PTR_OFS, rd);
    `CHK(rd, wp);
    reg_wr(READ_PTR_OFS, 16'h0002);
    push_entry();
    push_entry();
    expect_beats(2, 1'b0);
    reg_rd(WRITE_PTR_OFS, rd);
    `CHK(rd, 16'h0001);
    `CHK(wrPulses, 5);
    $display("test single writes done");
    endOfs = 16'hffff;
    reg_wr(END_OFS, endOfs);
    reg_wr(READ_PTR_OFS, 16'h0001);
    for (int c = 0; c < 8; c++) begin
      queueWriteIntEnable <= 1'($urandom);
      reg_wr(CTRL_OFS, 16'(c) << THR_LSB);
      n0 = wrPulses;
      repeat ((1 << c) - 1) push_entry();
      expect_beats((1 << c) - 1, 1'b0);
      `CHK(wrPulses - n0, 0);
      push_entry();
      expect_beats(1, 1'b0);
      `CHK(wrPulses - n0, 1);
    end
    $display("test thresholds done");
    txDmaMasterEnable <= 1'b0;
    ackDelay <= 4'h3;
    reg_wr(FLUSH_TIMER_OFS, 16'h0004);
    reg_wr(CTRL_OFS, 16'h0001 << BURST_EN_BIT);
    repeat (BUF_DEPTH) push_entry();
    @(negedge ref_clk);
    `CHK(entryReady, 1'b0);
    @(posedge ref_clk);
    txDmaMasterEnable <= 1'b1;
    expect_beats(BUF_DEPTH, 1'b1);
    repeat (5) push_entry();
    repeat (100) @(posedge ref_clk);
    `CHK(beatAddr.size(), 0);
    push_entry();
    expect_beats(6, 1'b1);
    t0 = lastAck;
    push_entry();
    push_entry();
    expect_beats(2, 1'b1);
    `CHK(lastAck - t0 >= 3 * TIMER_DIV_CYCLES && lastAck - t0 <= 4 * TIMER_DIV_CYCLES + 40, 1);
    $display("test burst and timer done");
    endOfs = 16'h0007;
    reg_wr(END_OFS, endOfs);
    reg_wr(WRITE_PTR_OFS, 16'h0000);
    wp = 16'h0000;
    reg_wr(READ_PTR_OFS, 16'h0004);
    repeat (6) push_entry();
    expect_beats(3, 1'b1);
    reg_wr(READ_PTR_OFS, 16'h0000);
    reg_wr(CTRL_OFS, (16'h0001 << BURST_EN_BIT) | (16'h0001 << FLUSH_BIT));
    expect_beats(3, 1'b1);
    reg_wr(CTRL_OFS, 16'h0001 << BURST_EN_BIT);
    reg_wr(READ_PTR_OFS, 16'h0007);
    push_entry();
    reg_wr(CTRL_OFS, (16'h0001 << BURST_EN_BIT) | (16'h0001 << FLUSH_BIT));
    repeat (20) @(posedge ref_clk);
    `CHK(beatAddr.size(), 0);
    `CHK(errPulses, 2);
    void'(expQ.pop_front());
    reg_rd(WRITE_PTR_OFS, rd);
    `CHK(rd, 16'h0006);
    reg_wr(CTRL_OFS, 16'h0001 << BURST_EN_BIT);
    `CHK(irqCnt, irqExp);
    $display("test partial burst and flush done");
    give_verdict();
  end
endmodule
